// [core/aegl_defines.svh]
// Register offsets, field positions, reset values and limits of the auto exposure/gain loop
`ifndef AEGL_DEFINES_SVH
`define AEGL_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define AEGL_OFS_CTRL 8'h00
`define AEGL_OFS_EXPOSURE 8'h04
`define AEGL_OFS_EXP_FLOOR 8'h08
`define AEGL_OFS_EXP_CEIL 8'h0C
`define AEGL_OFS_GAIN 8'h10
`define AEGL_OFS_GAIN_FLOOR 8'h14
`define AEGL_OFS_GAIN_CEIL 8'h18
`define AEGL_OFS_GOAL 8'h1C
`define AEGL_OFS_SETTLE 8'h20
`define AEGL_OFS_STATUS 8'h24

// ************************************************************
// Control field positions
// ************************************************************
`define AEGL_CTRL_AE_LSB 0
`define AEGL_CTRL_AG_LSB 2
`define AEGL_CTRL_POLICY_BIT 4
`define AEGL_CTRL_TRIG_BIT 5
`define AEGL_CTRL_PIX12_BIT 6

// ************************************************************
// Limits and reset values
// ************************************************************
`define AEGL_EXP_MIN 24'h00000A
`define AEGL_EXP_MAX 24'h0F4240
`define AEGL_EXP_RST 24'h0003E8
`define AEGL_GAIN_MIN 12'h000
`define AEGL_GAIN_MAX 12'h1FF
`define AEGL_GAIN_RST 12'h000
`define AEGL_GOAL_RST 12'h080
`define AEGL_GOAL_MAX8 12'h0FF
`define AEGL_GOAL_MAX12 12'hFFF
`define AEGL_SETTLE_RST 10'h2BC
`define AEGL_SETTLE_MAX 10'h320
`define AEGL_SETTLE_SHIFT 10
`define AEGL_EXP_SHIFT 4

`endif

// [core/aegl_pkg.sv]
// Types shared by the auto exposure/gain loop modules
package aegl_pkg;

  // ************************************************************
  // Modes, policy and loop states
  // ************************************************************
  typedef enum logic [1:0] {
    aegl_mode_off = 2'h0,
    aegl_mode_once = 2'h1,
    aegl_mode_cont = 2'h2
  } aegl_mode_type;

  typedef enum logic {
    aegl_keep_gain_low = 1'h0,
    aegl_keep_exposure_low = 1'h1
  } aegl_policy_type;

  typedef enum logic [2:0] {
    aegl_st_idle = 3'h1,
    aegl_st_calc = 3'h2,
    aegl_st_apply = 3'h4
  } aegl_st_type;

  // ************************************************************
  // Control register layout, MSB first
  // ************************************************************
  typedef struct packed {
    logic pix12;
    logic trig_width;
    aegl_policy_type policy;
    aegl_mode_type ag_mode;
    aegl_mode_type ae_mode;
  } aegl_ctrl_type;

  // Whole state of the loop top
  typedef struct packed {
    aegl_ctrl_type ctrl;
    logic [23:0] exposure;
    logic [23:0] exp_floor;
    logic [23:0] exp_ceil;
    logic [11:0] gain;
    logic [11:0] gain_floor;
    logic [11:0] gain_ceil;
    logic [11:0] goal;
    logic [9:0] settle;
    aegl_st_type st;
    logic [11:0] mag;
    logic dir_up;
    logic ae_go;
    logic ag_go;
    logic reached;
    logic ack;
    logic [31:0] dat;
    logic stretch;
  } aegl_state_type;

  // Whole state of the damping multiplier
  typedef struct packed {
    logic done;
    logic [11:0] step;
  } aegl_mul_type;

endpackage : aegl_pkg

// [core/aegl_mul.sv]
// Damped step size: error magnitude times settle factor over 1024
`timescale 1ns/1ps
`default_nettype none
`include "aegl_defines.svh"

module aegl_mul
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic start_i,
  input wire logic [11:0] mag_i,
  input wire logic [9:0] factor_i,
  // Result
  output logic [11:0] step_o,
  output logic done_o
);

  aegl_pkg::aegl_mul_type q; // Registered state
  aegl_pkg::aegl_mul_type d; // Next state
  logic [21:0] prod; // Full product

  // ************************************************************
  // Scaled product
  // ************************************************************
  assign prod = mag_i * factor_i;

  // Capture the scaled product one cycle after start
  always_comb
  begin
    d = q;
    d.done = start_i;
    if (start_i)
    begin
      // Factor is a code scaled by 1/1024
      d.step = prod[21:`AEGL_SETTLE_SHIFT];
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign step_o = q.step;
  assign done_o = q.done;

endmodule : aegl_mul

`default_nettype wire

// [core/aegl_top.sv]
// Auto exposure and auto gain brightness loop with a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "aegl_defines.svh"

// Function
// - Trigger width exposure keeps auto exposure off
// - Adjust exposure within floor/ceiling toward goal
// - Exposure mode offers once and continuous
// - No window overlap: keep manual exposure
// - Floor and ceiling limited to model range (code clamps exposure limits only, not gain)
// - Goal range 255 or 4095 by format
// - Long exposure may reduce frame rate
// - One goal shared by both loops
// - Damping applied, reset value 0.6836
// - Damping factor limited to 0.78125
// - Larger factor converges in fewer frames
// - Policy only when both loops continuous
// - Policy keeps gain or exposure low
// - Reset policy keeps gain low
// - Gain varied only between floor and ceiling
module aegl_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Frame statistics
  input wire logic frame_end_i,
  input wire logic [11:0] mean_gray_i,
  input wire logic window_overlap_i,
  input wire logic [23:0] frame_period_i,
  // Applied settings
  output logic [23:0] exposure_duration_o,
  output logic [11:0] gain_code_o,
  output logic frame_stretch_o
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge32(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge32

  // Limit a value to a window
  function automatic logic [23:0] clamp24(input logic [23:0] v, input logic [23:0] lo,
                                          input logic [23:0] hi);
    logic [23:0] r;
    r = v;
    if (v < lo)
    begin
      r = lo;
    end
    else if (v > hi)
    begin
      r = hi;
    end
    return r;
  endfunction : clamp24

  // Saturating step up or down, then held inside the window
  function automatic logic [23:0] step24(input logic [23:0] cur, input logic [23:0] stp,
                                         input logic up, input logic [23:0] lo,
                                         input logic [23:0] hi);
    logic [24:0] s;
    logic [23:0] r;
    s = up ? ({1'b0, cur} + {1'b0, stp}) : ({1'b0, cur} - {1'b0, stp});
    if (up && s[24])
    begin
      r = 24'hFFFFFF;
    end
    else if (!up && s[24])
    begin
      r = 24'h000000;
    end
    else
    begin
      r = s[23:0];
    end
    return clamp24(r, lo, hi);
  endfunction : step24

  // Illegal mode code reads as off
  function automatic aegl_pkg::aegl_mode_type legal_mode(input logic [1:0] v);
    return (v == 2'h3) ? aegl_pkg::aegl_mode_off : aegl_pkg::aegl_mode_type'(v);
  endfunction : legal_mode

  // ************************************************************
  // Declarations
  // ************************************************************
  aegl_pkg::aegl_state_type q; // Registered state
  aegl_pkg::aegl_state_type d; // Next state
  logic take; // Bus request accepted this cycle
  logic wr; // Accepted write
  logic [31:0] wmerge; // Write data merged over old word
  logic [31:0] rdata; // Read mux
  logic [11:0] goal_max; // Goal ceiling for the pixel format
  logic [11:0] goal_eff; // Goal used by both loops
  logic [11:0] mul_step; // Damped step from multiplier
  logic mul_done; // Multiplier result valid
  logic [11:0] step_eff; // Step of at least one code
  logic ae_ok; // Exposure loop may run this frame
  logic ag_ok; // Gain loop may run this frame
  logic both_cont; // Both loops continuous
  logic exp_room; // Exposure can still move
  logic gain_room; // Gain can still move
  logic prefer_exp; // Policy picks exposure
  logic do_exp; // Adjust exposure now
  logic do_gain; // Adjust gain now

  // ************************************************************
  // Bus decode and read mux
  // ************************************************************
  assign take = cyc_i && stb_i && !q.ack;
  assign wr = take && we_i;
  assign goal_max = q.ctrl.pix12 ? `AEGL_GOAL_MAX12 : `AEGL_GOAL_MAX8;
  // Shared goal, clipped to the current format
  assign goal_eff = (q.goal > goal_max) ? goal_max : q.goal;

  // Old word of the addressed register, merged with the write
  always_comb
  begin
    rdata = 32'h00000000;
    unique case (adr_i)
      `AEGL_OFS_CTRL: rdata = {25'h0000000, q.ctrl};
      `AEGL_OFS_EXPOSURE: rdata = {8'h00, q.exposure};
      `AEGL_OFS_EXP_FLOOR: rdata = {8'h00, q.exp_floor};
      `AEGL_OFS_EXP_CEIL: rdata = {8'h00, q.exp_ceil};
      `AEGL_OFS_GAIN: rdata = {20'h00000, q.gain};
      `AEGL_OFS_GAIN_FLOOR: rdata = {20'h00000, q.gain_floor};
      `AEGL_OFS_GAIN_CEIL: rdata = {20'h00000, q.gain_ceil};
      `AEGL_OFS_GOAL: rdata = {20'h00000, goal_eff};
      `AEGL_OFS_SETTLE: rdata = {22'h000000, q.settle};
      `AEGL_OFS_STATUS: rdata = {28'h0000000, q.stretch, q.reached, q.ag_go, q.ae_go};
      default: rdata = 32'h00000000;
    endcase
  end
  assign wmerge = merge32(rdata, dat_i, sel_i);

  // ************************************************************
  // Loop decisions
  // ************************************************************
  // Trigger width exposure blocks the exposure loop
  // Window without overlap leaves the manual values
  assign ae_ok = (q.ctrl.ae_mode != aegl_pkg::aegl_mode_off) && !q.ctrl.trig_width &&
                 window_overlap_i;
  assign ag_ok = (q.ctrl.ag_mode != aegl_pkg::aegl_mode_off) && window_overlap_i;
  assign step_eff = ((mul_step == 12'h000) && (q.mag != 12'h000)) ? 12'h001 : mul_step;
  // Policy only when both loops run continuous
  assign both_cont = q.ae_go && q.ag_go && (q.ctrl.ae_mode == aegl_pkg::aegl_mode_cont) &&
                     (q.ctrl.ag_mode == aegl_pkg::aegl_mode_cont);
  assign exp_room = q.dir_up ? (q.exposure < q.exp_ceil) : (q.exposure > q.exp_floor);
  assign gain_room = q.dir_up ? (q.gain < q.gain_ceil) : (q.gain > q.gain_floor);
  // Keep gain low: exposure first going up, gain first going down
  assign prefer_exp = (q.ctrl.policy == aegl_pkg::aegl_keep_gain_low) ?
                      (q.dir_up ? exp_room : !gain_room) :
                      (q.dir_up ? !gain_room : exp_room);
  assign do_exp = both_cont ? prefer_exp : q.ae_go;
  assign do_gain = both_cont ? !prefer_exp : q.ag_go;

  // Damped step, larger factor gives larger steps
  aegl_mul aegl_mul_i
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(q.st == aegl_pkg::aegl_st_calc),
    .mag_i(q.mag),
    .factor_i(q.settle),
    .step_o(mul_step),
    .done_o(mul_done)
  );

  // ************************************************************
  // Next state: frame loop, then bus writes
  // ************************************************************
  always_comb
  begin
    d = q;
    d.ack = take;
    d.dat = (take && !we_i) ? rdata : 32'h00000000;
    // Exposure past the frame period stretches the frame
    d.stretch = q.exposure > frame_period_i;
    unique case (q.st)
      aegl_pkg::aegl_st_idle:
      begin
        // Measure once per frame end
        if (frame_end_i && (ae_ok || ag_ok))
        begin
          d.ae_go = ae_ok;
          d.ag_go = ag_ok;
          d.dir_up = goal_eff > mean_gray_i;
          d.mag = (goal_eff > mean_gray_i) ? (goal_eff - mean_gray_i) :
                  (mean_gray_i - goal_eff);
          d.st = aegl_pkg::aegl_st_calc;
        end
      end
      aegl_pkg::aegl_st_calc:
      begin
        // Multiplier works this cycle
        d.st = aegl_pkg::aegl_st_apply;
      end
      aegl_pkg::aegl_st_apply:
      begin
        d.st = aegl_pkg::aegl_st_idle;
        d.reached = (q.mag == 12'h000);
        if (mul_done && (q.mag != 12'h000))
        begin
          if (do_exp)
          begin
            // Exposure kept between floor and ceiling
            d.exposure = step24(q.exposure, {12'h000, step_eff} << `AEGL_EXP_SHIFT, q.dir_up,
                                q.exp_floor, q.exp_ceil);
          end
          if (do_gain)
          begin
            // Gain kept between floor and ceiling
            d.gain = 12'(step24({12'h000, q.gain}, {12'h000, step_eff}, q.dir_up,
                                {12'h000, q.gain_floor}, {12'h000, q.gain_ceil}));
          end
        end
        // Once mode ends at the goal and turns off
        if ((q.mag == 12'h000) && q.ae_go && (q.ctrl.ae_mode == aegl_pkg::aegl_mode_once))
        begin
          d.ctrl.ae_mode = aegl_pkg::aegl_mode_off;
        end
        if ((q.mag == 12'h000) && q.ag_go && (q.ctrl.ag_mode == aegl_pkg::aegl_mode_once))
        begin
          d.ctrl.ag_mode = aegl_pkg::aegl_mode_off;
        end
      end
    endcase
    // Software writes override the loop in the same cycle
    if (wr)
    begin
      unique case (adr_i)
        `AEGL_OFS_CTRL:
        begin
          d.ctrl.ae_mode = legal_mode(wmerge[`AEGL_CTRL_AE_LSB +: 2]);
          d.ctrl.ag_mode = legal_mode(wmerge[`AEGL_CTRL_AG_LSB +: 2]);
          d.ctrl.policy = aegl_pkg::aegl_policy_type'(wmerge[`AEGL_CTRL_POLICY_BIT]);
          d.ctrl.trig_width = wmerge[`AEGL_CTRL_TRIG_BIT];
          d.ctrl.pix12 = wmerge[`AEGL_CTRL_PIX12_BIT];
        end
        `AEGL_OFS_EXPOSURE: d.exposure = clamp24(wmerge[23:0], `AEGL_EXP_MIN, `AEGL_EXP_MAX);
        // Exposure limits held to the model range; gain limits are not clamped
        `AEGL_OFS_EXP_FLOOR: d.exp_floor = clamp24(wmerge[23:0], `AEGL_EXP_MIN, `AEGL_EXP_MAX);
        `AEGL_OFS_EXP_CEIL: d.exp_ceil = clamp24(wmerge[23:0], `AEGL_EXP_MIN, `AEGL_EXP_MAX);
        `AEGL_OFS_GAIN: d.gain = wmerge[11:0];
        `AEGL_OFS_GAIN_FLOOR: d.gain_floor = wmerge[11:0];
        `AEGL_OFS_GAIN_CEIL: d.gain_ceil = wmerge[11:0];
        `AEGL_OFS_GOAL: d.goal = wmerge[11:0];
        // Factor code capped at 800
        `AEGL_OFS_SETTLE: d.settle = (wmerge[9:0] > `AEGL_SETTLE_MAX) ? `AEGL_SETTLE_MAX :
                                     wmerge[9:0];
        default: d.dat = 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.exposure <= `AEGL_EXP_RST;
      q.exp_floor <= `AEGL_EXP_MIN;
      q.exp_ceil <= `AEGL_EXP_MAX;
      q.gain <= `AEGL_GAIN_RST;
      q.gain_floor <= `AEGL_GAIN_MIN;
      q.gain_ceil <= `AEGL_GAIN_MAX;
      q.goal <= `AEGL_GOAL_RST;
      q.settle <= `AEGL_SETTLE_RST;
      q.ctrl.policy <= aegl_pkg::aegl_keep_gain_low;
      q.st <= aegl_pkg::aegl_st_idle;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign dat_o = q.dat;
  assign ack_o = q.ack;
  assign exposure_duration_o = q.exposure;
  assign gain_code_o = q.gain;
  assign frame_stretch_o = q.stretch;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_trig_holds_exp:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (q.st == aegl_pkg::aegl_st_apply && q.ctrl.trig_width && !wr)
    |=> $stable(q.exposure))
  else $error("exposure loop armed in trigger width mode");

  a_exp_in_window:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (q.st == aegl_pkg::aegl_st_apply && q.ae_go && !wr && q.exp_floor <= q.exp_ceil &&
     q.exposure >= q.exp_floor && q.exposure <= q.exp_ceil)
    |=> (q.exposure >= q.exp_floor) && (q.exposure <= q.exp_ceil))
  else $error("exposure left its window");

  a_no_overlap_idle:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (q.st == aegl_pkg::aegl_st_idle && frame_end_i && !window_overlap_i)
    |=> (q.st == aegl_pkg::aegl_st_idle))
  else $error("loop started without window overlap");

  a_exp_limits_legal:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (q.exp_floor >= `AEGL_EXP_MIN) && (q.exp_ceil <= `AEGL_EXP_MAX))
  else $error("exposure limit outside model range");

  a_goal_in_format:
  assert property (@(posedge clk_i) disable iff (rst_i)
    !q.ctrl.pix12 |-> (goal_eff <= 12'h0FF))
  else $error("goal above 8-bit range");

  a_settle_capped:
  assert property (@(posedge clk_i) disable iff (rst_i)
    q.settle <= 10'h320)
  else $error("settle factor code above cap");

  a_gain_low_policy:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (q.st == aegl_pkg::aegl_st_apply && both_cont && q.dir_up && exp_room &&
     q.ctrl.policy == aegl_pkg::aegl_keep_gain_low && !wr)
    |=> $stable(q.gain))
  else $error("gain raised while exposure had room");

  a_once_turns_off:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (q.st == aegl_pkg::aegl_st_calc && q.mag == 12'h000 && q.ae_go &&
     q.ctrl.ae_mode == aegl_pkg::aegl_mode_once) ##1 !wr
    |=> (q.ctrl.ae_mode == aegl_pkg::aegl_mode_off))
  else $error("once mode did not turn off at goal");

  a_frame_to_apply:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (q.st == aegl_pkg::aegl_st_idle && frame_end_i && (ae_ok || ag_ok))
    |=> (q.st == aegl_pkg::aegl_st_calc) ##1 (q.st == aegl_pkg::aegl_st_apply) ##1
        (q.st == aegl_pkg::aegl_st_idle))
  else $error("frame step sequence broken");

endmodule : aegl_top

`default_nettype wire

// [tb/aegl_top_tb.sv]
// Self-checking testbench of the auto exposure/gain loop
`timescale 1ns/1ps
`default_nettype none
`include "aegl_defines.svh"

module aegl_top_tb;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic frame_end_i = 1'b0;
  logic [11:0] mean_gray_i = 12'h000;
  logic window_overlap_i = 1'b1;
  logic [23:0] frame_period_i = 24'hFFFFFF;
  logic [23:0] exposure_duration_o;
  logic [11:0] gain_code_o;
  logic frame_stretch_o;
  int fail_count = 0; // Mismatches
  int checks = 0; // Comparisons

  aegl_top aegl_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .frame_end_i(frame_end_i), .mean_gray_i(mean_gray_i),
    .window_overlap_i(window_overlap_i), .frame_period_i(frame_period_i),
    .exposure_duration_o(exposure_duration_o), .gain_code_o(gain_code_o),
    .frame_stretch_o(frame_stretch_o));

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : check

  // Classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd

  // One frame end with statistics, then let the loop settle
  task automatic frame(input logic [11:0] m);
    @(posedge clk_i);
    frame_end_i <= 1'b1;
    mean_gray_i <= m;
    @(posedge clk_i);
    frame_end_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : frame

  // Back to reset-like limits and manual values
  task automatic restore(input logic [31:0] c);
    wr(`AEGL_OFS_CTRL, c);
    wr(`AEGL_OFS_EXPOSURE, 32'h3E8);
    wr(`AEGL_OFS_GAIN, 32'h0);
    wr(`AEGL_OFS_EXP_CEIL, 32'hF4240);
    wr(`AEGL_OFS_EXP_FLOOR, 32'hA);
    wr(`AEGL_OFS_GAIN_CEIL, 32'h1FF);
  endtask : restore

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rd(`AEGL_OFS_CTRL, 32'h0);
    rd(`AEGL_OFS_SETTLE, 32'h2BC);
    rd(`AEGL_OFS_EXP_FLOOR, 32'hA);
    rd(`AEGL_OFS_EXP_CEIL, 32'hF4240);
    rd(`AEGL_OFS_GAIN_CEIL, 32'h1FF);
    rd(`AEGL_OFS_GOAL, 32'h80);
    rd(8'h40, 32'h0);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_limits();
    wr(`AEGL_OFS_SETTLE, 32'h3FF);
    rd(`AEGL_OFS_SETTLE, 32'h320);
    wr(`AEGL_OFS_SETTLE, 32'h2BC);
    wr(`AEGL_OFS_EXP_CEIL, 32'hFFFFFF);
    rd(`AEGL_OFS_EXP_CEIL, 32'hF4240);
    wr(`AEGL_OFS_GOAL, 32'h300);
    rd(`AEGL_OFS_GOAL, 32'hFF);
    wr(`AEGL_OFS_CTRL, 32'h40);
    rd(`AEGL_OFS_GOAL, 32'h300);
    wr(`AEGL_OFS_GOAL, 32'h80);
    wr(`AEGL_OFS_CTRL, 32'h0);
    wr(`AEGL_OFS_CTRL, 32'hF);
    rd(`AEGL_OFS_CTRL, 32'h0);
    $display("test limits done");
  endtask : t_limits

  // Continuous exposure: step (64*700)>>10 = 43, moved by 43<<4
  task automatic t_exposure();
    restore(32'h2);
    frame(12'h040);
    check(exposure_duration_o, 32'h698);
    wr(`AEGL_OFS_EXPOSURE, 32'h3E8);
    wr(`AEGL_OFS_EXP_CEIL, 32'h400);
    frame(12'h040);
    check(exposure_duration_o, 32'h400);
    wr(`AEGL_OFS_EXP_FLOOR, 32'h3E0);
    frame(12'h0C0);
    check(exposure_duration_o, 32'h3E0);
    // Larger factor: step (64*800)>>10 = 50, moved by 50<<4
    restore(32'h2);
    wr(`AEGL_OFS_SETTLE, 32'h320);
    frame(12'h040);
    check(exposure_duration_o, 32'h708);
    wr(`AEGL_OFS_SETTLE, 32'h2BC);
    $display("test exposure loop done");
  endtask : t_exposure

  // Trigger width mode and missing overlap leave manual value
  task automatic t_manual();
    restore(32'h2A);
    frame(12'h040);
    check(exposure_duration_o, 32'h3E8);
    check(gain_code_o, 32'h2B);
    wr(`AEGL_OFS_CTRL, 32'h2);
    window_overlap_i <= 1'b0;
    frame(12'h040);
    check(exposure_duration_o, 32'h3E8);
    window_overlap_i <= 1'b1;
    $display("test manual hold done");
  endtask : t_manual

  // Single shot at goal turns its mode off
  task automatic t_once();
    restore(32'h1);
    frame(12'h080);
    rd(`AEGL_OFS_CTRL, 32'h0);
    rd(`AEGL_OFS_STATUS, 32'h5);
    check(exposure_duration_o, 32'h3E8);
    $display("test single shot done");
  endtask : t_once

  // Gain loop clamps at its ceiling
  task automatic t_gain();
    restore(32'h8);
    wr(`AEGL_OFS_GAIN_CEIL, 32'h5);
    frame(12'h000);
    check(gain_code_o, 32'h5);
    check(exposure_duration_o, 32'h3E8);
    $display("test gain loop done");
  endtask : t_gain

  // Both continuous: policy picks which quantity moves
  task automatic t_policy();
    restore(32'hA);
    frame(12'h040);
    check(exposure_duration_o, 32'h698);
    check(gain_code_o, 32'h0);
    restore(32'h1A);
    frame(12'h040);
    check(gain_code_o, 32'h2B);
    check(exposure_duration_o, 32'h3E8);
    $display("test balance policy done");
  endtask : t_policy

  // Exposure longer than the frame period stretches the frame
  task automatic t_stretch();
    restore(32'h0);
    check(frame_stretch_o, 32'h0);
    frame_period_i <= 24'h000100;
    repeat (4) @(posedge clk_i);
    check(frame_stretch_o, 32'h1);
    frame_period_i <= 24'hFFFFFF;
    $display("test frame stretch done");
  endtask : t_stretch

  // ************************************************************
  // Verdict, watchdog and main sequence
  // ************************************************************
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Cuts a hang well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end

  // Reset for 12 cycles, then all scenarios
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_limits();
    t_exposure();
    t_manual();
    t_once();
    t_gain();
    t_policy();
    t_stretch();
    give_verdict();
  end
endmodule : aegl_top_tb
`default_nettype wire
